// >>> src/ufc_pkg.sv
package ufc_pkg;

	// Register byte offsets on the APB slave
	localparam logic [7:0] OFF_DATA      = 8'h00;
	localparam logic [7:0] OFF_DIV_HIGH  = 8'h04;
	localparam logic [7:0] OFF_FIFO_CTL  = 8'h08;
	localparam logic [7:0] OFF_LINE_FMT  = 8'h0C;
	localparam logic [7:0] OFF_MODEM_OUT = 8'h10;
	localparam logic [7:0] OFF_ENH_FEAT  = 8'h14;
	localparam logic [7:0] OFF_FEAT_CTL  = 8'h18;
	localparam logic [7:0] OFF_DIV_FRAC  = 8'h1C;
	localparam logic [7:0] OFF_STATUS    = 8'h20;

	// fifo_control fields
	localparam int FC_ENABLE  = 0;
	localparam int FC_RX_RST  = 1;
	localparam int FC_TX_RST  = 2;
	localparam int FC_TX_TRIG = 4;
	localparam int FC_RX_TRIG = 6;

	// line_format_control fields
	localparam int LF_WLEN      = 0;
	localparam int LF_STOP      = 2;
	localparam int LF_PAR_EN    = 3;
	localparam int LF_PAR_EVEN  = 4;
	localparam int LF_PAR_FORCE = 5;
	localparam int LF_BREAK     = 6;
	localparam int LF_DIV_ACC   = 7;

	// modem_output_control, enhanced_feature_control, feature_control fields
	localparam int MO_TERM_RDY  = 0;
	localparam int MO_SEND_REQ  = 1;
	localparam int EF_ENHANCED  = 4;
	localparam int EF_AUTO_SEND = 6;
	localparam int FT_RS485     = 3;

	// Reset values
	localparam logic [7:0] LINE_FMT_RST  = 8'h05;
	localparam logic [7:0] MODEM_OUT_RST = 8'h00;
	localparam logic [7:0] ENH_FEAT_RST  = 8'h00;
	localparam logic [7:0] FEAT_CTL_RST  = 8'h00;
	localparam logic [1:0] TRIG_CODE_RST = 2'h0;
	localparam logic [7:0] DIV_LOW_RST   = 8'h01;
	localparam logic [7:0] DIV_HIGH_RST  = 8'h00;
	localparam logic [3:0] DIV_FRAC_RST  = 4'h0;

	// Sizes and timing counts
	localparam int         FIFO_DEPTH      = 64;
	localparam int         LVL_W           = 7;
	localparam logic [6:0] TOUT_CHARS      = 7'h04;
	localparam logic [6:0] TOUT_EXTRA_BITS = 7'h0C;

	typedef struct packed {
		logic [3:0] word_bits;
		logic       stop_two;
		logic       stop_half;
		logic       parity_en;
		logic       parity_forced;
		logic       parity_even;
	} ufc_fmt_t;

	typedef struct packed {
		logic       enable;
		logic [1:0] tx_trig;
		logic [1:0] rx_trig;
	} ufc_fifo_cfg_t;

	function automatic logic [6:0] ufc_tx_trig_lvl(input logic [1:0] code);
		case (code)
			2'h0:    return 7'h08;
			2'h1:    return 7'h10;
			2'h2:    return 7'h20;
			default: return 7'h38;
		endcase
	endfunction : ufc_tx_trig_lvl

	function automatic logic [6:0] ufc_rx_trig_lvl(input logic [1:0] code);
		case (code)
			2'h0:    return 7'h08;
			2'h1:    return 7'h10;
			2'h2:    return 7'h38;
			default: return 7'h3C;
		endcase
	endfunction : ufc_rx_trig_lvl

endpackage : ufc_pkg

// >>> src/ufc_fifo_level.sv
`timescale 1ns/1ps
module ufc_fifo_level
	import ufc_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             clr,
	input  wire logic             push,
	input  wire logic             pop,
	input  wire logic [LVL_W-1:0] limit,
	output logic      [LVL_W-1:0] level,
	output logic                  full,
	output logic                  empty
);

	logic do_push;
	logic do_pop;

	// Overflow and underflow requests are dropped, never wrapped
	assign full    = (level >= limit);
	assign empty   = (level == '0);
	assign do_push = push & ~full;
	assign do_pop  = pop & ~empty;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level <= '0;
		end else if (clr) begin
			level <= '0;
		end else if (do_push & ~do_pop) begin
			level <= level + 1'b1;
		end else if (do_pop & ~do_push) begin
			level <= level - 1'b1;
		end
	end

	level_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
		level <= LVL_W'(DEPTH)) else $error("level above depth");

endmodule : ufc_fifo_level

// >>> src/ufc_rx_timeout.sv
`timescale 1ns/1ps
module ufc_rx_timeout
	import ufc_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       bit_tick,
	input  wire logic       restart,
	input  wire logic       armed,
	input  wire logic       clear,
	input  wire logic [6:0] limit,
	output logic            timeout
);

	logic [6:0] cnt;

	// Count bit times of silence while data waits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
		end else if (restart || !armed) begin
			cnt <= '0;
		end else if (bit_tick && cnt != limit) begin
			cnt <= cnt + 7'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timeout <= 1'b0;
		end else if (!armed || clear) begin
			timeout <= 1'b0;
		end else if (cnt == limit && !restart) begin
			timeout <= 1'b1; // [RL21]
		end
	end

	tout_fire_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL21]
		$rose(timeout) |-> $past(cnt) == $past(limit) && $past(armed))
		else $error("timeout fired early");

endmodule : ufc_rx_timeout

// >>> src/ufc_uart_ctl.sv
// Operation
// [RL1] FIFO-enable clear runs without FIFOs; set enables both FIFOs.
// [RL2] Other FIFO-control fields load only when the same write sets enable.
// [RL3] Receive FIFO reset bit clears receive level, then self-clears.
// [RL4] Transmit FIFO reset bit clears transmit level, then self-clears.
// [RL5] FIFO-control bit three does nothing.
// [RL6] Transmit trigger selects 8/16/32/56 spaces; writable only with enhanced enable.
// [RL7] Transmit request when free spaces exceed trigger, or FIFO empties.
// [RL8] Receive trigger selects 8/16/56/60 characters, default 8.
// [RL9] Receive request when count exceeds trigger or receive timeout occurs.
// [RL10] Word length code selects 5, 6, 7 or 8 bits, default 6.
// [RL11] Stop bit: one, else one and a half for 5 bits, two otherwise.
// [RL12] Parity enable adds parity on transmit and checks it on receive.
// [RL13] Parity type bit: clear means odd, set means even, both directions.
// [RL14] Forced parity: bit is one when type clear, zero when type set.
// [RL15] Break bit holds serial output low until software clears it.
// [RL16] Divisor access bit maps divisor latches over the data registers.
// [RL17] Terminal-ready bit drives its active-low output low when set.
// [RL18] Send-request bit drives its active-low output unless automatic control owns it.
// [RL19] Send-request pin follows auto flow control or half-duplex direction control.
// [RL20] FIFO-control register is write-only; reads return status instead.
// [RL21] Receive timeout after four characters plus twelve bit times of silence.
// [RL22] Each FIFO holds 64 characters; counts range 0 to 64.
`timescale 1ns/1ps
module ufc_uart_ctl
	import ufc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        bit_tick,
	input  wire logic        tx_serial_bit,
	input  wire logic        tx_pop,
	input  wire logic        tx_busy,
	input  wire logic [7:0]  tx_char,
	input  wire logic        rx_push,
	input  wire logic        rx_activity,
	input  wire logic [7:0]  rx_char,
	input  wire logic        rx_parity_in,
	input  wire logic        rx_check,
	input  wire logic        auto_send_req_n,
	output logic             tx_pin,
	output logic             term_ready_n,
	output logic             send_req_n,
	output logic             host_wr_valid,
	output logic      [7:0]  host_wr_byte,
	output logic             tx_fifo_clr,
	output logic             rx_fifo_clr,
	output logic             tx_parity_bit,
	output logic             rx_parity_err,
	output logic             tx_irq_req,
	output logic             rx_irq_req,
	output ufc_fmt_t         fmt,
	output ufc_fifo_cfg_t    fifo_cfg,
	output logic      [7:0]  div_low,
	output logic      [7:0]  div_high,
	output logic      [3:0]  div_frac
);

	logic [7:0]       line_fmt;
	logic [7:0]       modem_out;
	logic [7:0]       enh_feat;
	logic [7:0]       feat_ctl;
	logic             access;
	logic             wr_en;
	logic             rd_en;
	logic             setup;
	logic             addr_hit;
	logic             div_acc;
	logic             wr_fc;
	logic             fc_ok;
	logic             rx_clr;
	logic             tx_clr;
	logic             fifo_toggle;
	logic             data_rd;
	logic [LVL_W-1:0] limit;
	logic [LVL_W-1:0] tx_level;
	logic [LVL_W-1:0] rx_level;
	logic [LVL_W-1:0] tx_free;
	logic [LVL_W-1:0] tx_trig_lvl;
	logic [LVL_W-1:0] rx_trig_lvl;
	logic             tx_empty;
	logic             rx_empty;
	logic             rx_timeout;
	logic [6:0]       char_bits;
	logic [6:0]       tout_limit;
	logic [7:0]       wmask;
	logic [31:0]      next_prdata;
	logic [31:0]      status_word;

	// APB slave: zero wait states, errors on unmapped offsets
	assign access  = psel & penable;
	assign setup   = psel & ~penable;
	assign wr_en   = access & pwrite & addr_hit;
	assign rd_en   = access & ~pwrite & addr_hit;
	assign pready  = 1'b1;
	assign pslverr = access & ~addr_hit;
	assign div_acc = line_fmt[LF_DIV_ACC];

	always_comb begin
		case (paddr)
			OFF_DATA, OFF_FIFO_CTL, OFF_LINE_FMT, OFF_MODEM_OUT,
			OFF_ENH_FEAT, OFF_FEAT_CTL, OFF_STATUS: addr_hit = 1'b1;
			OFF_DIV_HIGH, OFF_DIV_FRAC: addr_hit = div_acc; // [RL16]
			default: addr_hit = 1'b0;
		endcase
	end

	assign wr_fc  = wr_en && paddr == OFF_FIFO_CTL;
	assign fc_ok  = wr_fc && pwdata[FC_ENABLE]; // [RL2]
	assign rx_clr = fc_ok && pwdata[FC_RX_RST]; // [RL3]
	assign tx_clr = fc_ok && pwdata[FC_TX_RST]; // [RL4]
	assign fifo_toggle = wr_fc && (pwdata[FC_ENABLE] != fifo_cfg.enable);
	assign data_rd = rd_en && paddr == OFF_DATA && !div_acc;

	// Bit three is accepted and dropped on purpose
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fifo_cfg <= '{enable: 1'b0, tx_trig: TRIG_CODE_RST,
				rx_trig: TRIG_CODE_RST};
		end else if (wr_fc) begin // [RL5]
			fifo_cfg.enable <= pwdata[FC_ENABLE]; // [RL1]
			if (pwdata[FC_ENABLE]) begin
				fifo_cfg.rx_trig <= pwdata[FC_RX_TRIG +: 2]; // [RL8]
				if (enh_feat[EF_ENHANCED]) begin
					fifo_cfg.tx_trig <= pwdata[FC_TX_TRIG +: 2]; // [RL6]
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_fmt <= LINE_FMT_RST;
		end else if (wr_en && paddr == OFF_LINE_FMT) begin
			line_fmt <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			modem_out <= MODEM_OUT_RST;
			enh_feat  <= ENH_FEAT_RST;
			feat_ctl  <= FEAT_CTL_RST;
		end else if (wr_en) begin
			if (paddr == OFF_MODEM_OUT) begin
				modem_out <= pwdata[7:0];
			end
			if (paddr == OFF_ENH_FEAT) begin
				enh_feat <= pwdata[7:0];
			end
			if (paddr == OFF_FEAT_CTL) begin
				feat_ctl <= pwdata[7:0];
			end
		end
	end

	// Low divisor latch shares the data offset while access is set; high and fraction latches have their own offsets
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_low  <= DIV_LOW_RST;
			div_high <= DIV_HIGH_RST;
			div_frac <= DIV_FRAC_RST;
		end else if (wr_en && div_acc) begin
			if (paddr == OFF_DATA) begin
				div_low <= pwdata[7:0]; // [RL16]
			end
			if (paddr == OFF_DIV_HIGH) begin
				div_high <= pwdata[7:0];
			end
			if (paddr == OFF_DIV_FRAC) begin
				div_frac <= pwdata[3:0];
			end
		end
	end

	// Host character write, handed to the transmit datapath
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_wr_valid <= 1'b0;
			host_wr_byte  <= 8'h00;
		end else begin
			host_wr_valid <= wr_en && paddr == OFF_DATA && !div_acc;
			if (wr_en && paddr == OFF_DATA && !div_acc) begin
				host_wr_byte <= pwdata[7:0];
			end
		end
	end

	// Reset bits are never stored, so they read back as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_fifo_clr <= 1'b0;
			rx_fifo_clr <= 1'b0;
		end else begin
			tx_fifo_clr <= tx_clr | fifo_toggle; // [RL4]
			rx_fifo_clr <= rx_clr | fifo_toggle; // [RL3]
		end
	end

	// Without FIFOs each path holds a single character
	assign limit = fifo_cfg.enable ? LVL_W'(FIFO_DEPTH) : LVL_W'(1); // [RL22]

	ufc_fifo_level #(
		.DEPTH (FIFO_DEPTH)
	) u_tx_level (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (tx_clr | fifo_toggle),
		.push    (host_wr_valid),
		.pop     (tx_pop),
		.limit   (limit),
		.level   (tx_level),
		.full    (),
		.empty   (tx_empty)
	);

	ufc_fifo_level #(
		.DEPTH (FIFO_DEPTH)
	) u_rx_level (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (rx_clr | fifo_toggle),
		.push    (rx_push),
		.pop     (data_rd),
		.limit   (limit),
		.level   (rx_level),
		.full    (),
		.empty   (rx_empty)
	);

	// Character format decode
	always_comb begin
		fmt.word_bits     = 4'h5 + {2'h0, line_fmt[LF_WLEN +: 2]}; // [RL10]
		fmt.stop_two      = line_fmt[LF_STOP] && line_fmt[1:0] != 2'h0;
		fmt.stop_half     = line_fmt[LF_STOP] && line_fmt[1:0] == 2'h0;
		fmt.parity_en     = line_fmt[LF_PAR_EN]; // [RL12]
		fmt.parity_forced = line_fmt[LF_PAR_FORCE];
		fmt.parity_even   = line_fmt[LF_PAR_EVEN];
	end

	// One and a half stop bits round up to two for the timer
	assign char_bits  = 7'h01 + {3'h0, fmt.word_bits}
		+ {6'h00, fmt.parity_en}
		+ ((fmt.stop_two | fmt.stop_half) ? 7'h02 : 7'h01); // [RL11]
	assign tout_limit = 7'(char_bits * TOUT_CHARS) + TOUT_EXTRA_BITS; // [RL21]

	ufc_rx_timeout u_rx_timeout (
		.pclk     (pclk),
		.presetn  (presetn),
		.bit_tick (bit_tick),
		.restart  (rx_push | rx_activity | data_rd),
		.armed    (fifo_cfg.enable & ~rx_empty),
		.clear    (data_rd),
		.limit    (tout_limit),
		.timeout  (rx_timeout)
	);

	// Unused high data bits must not disturb parity
	assign wmask = 8'hFF >> (2'h3 - line_fmt[LF_WLEN +: 2]);

	function automatic logic parity_of(input logic [7:0] c,
		input logic [7:0] m, input ufc_fmt_t f);
		if (f.parity_forced) begin
			return ~f.parity_even; // [RL14]
		end
		return (^(c & m)) ^ ~f.parity_even; // [RL13]
	endfunction : parity_of

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_parity_bit <= 1'b0;
			rx_parity_err <= 1'b0;
		end else begin
			tx_parity_bit <= parity_of(tx_char, wmask, fmt); // [RL13]
			rx_parity_err <= rx_check && fmt.parity_en
				&& rx_parity_in != parity_of(rx_char, wmask, fmt); // [RL12]
		end
	end

	assign tx_free     = LVL_W'(FIFO_DEPTH) - tx_level;
	assign tx_trig_lvl = ufc_tx_trig_lvl(fifo_cfg.tx_trig);
	assign rx_trig_lvl = ufc_rx_trig_lvl(fifo_cfg.rx_trig);

	// Empty FIFO always exceeds any trigger, covering a short reload
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_irq_req <= 1'b0;
			rx_irq_req <= 1'b0;
		end else if (fifo_cfg.enable) begin
			tx_irq_req <= tx_free > tx_trig_lvl || tx_empty; // [RL7]
			rx_irq_req <= rx_level > rx_trig_lvl || rx_timeout; // [RL9]
		end else begin
			tx_irq_req <= tx_empty;
			rx_irq_req <= !rx_empty;
		end
	end

	// Serial and modem outputs, registered to avoid glitches on pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_pin       <= 1'b1;
			term_ready_n <= 1'b1;
			send_req_n   <= 1'b1;
		end else begin
			tx_pin       <= line_fmt[LF_BREAK] ? 1'b0 : tx_serial_bit; // [RL15]
			term_ready_n <= ~modem_out[MO_TERM_RDY]; // [RL17]
			if (feat_ctl[FT_RS485]) begin
				send_req_n <= ~tx_busy; // [RL19]
			end else if (enh_feat[EF_AUTO_SEND]) begin
				send_req_n <= auto_send_req_n; // [RL19]
			end else begin
				send_req_n <= ~modem_out[MO_SEND_REQ]; // [RL18]
			end
		end
	end

	assign status_word = {12'h000, rx_timeout, fifo_cfg.enable, rx_irq_req,
		tx_irq_req, 1'b0, rx_level, 1'b0, tx_level};

	always_comb begin
		case (paddr)
			OFF_DATA:      next_prdata = {24'h000000, div_acc ? div_low : rx_char};
			OFF_DIV_HIGH:  next_prdata = {24'h000000, div_high};
			OFF_DIV_FRAC:  next_prdata = {28'h0000000, div_frac};
			OFF_FIFO_CTL:  next_prdata = {24'h000000, {2{fifo_cfg.enable}},
				6'h00}; // [RL20]
			OFF_LINE_FMT:  next_prdata = {24'h000000, line_fmt};
			OFF_MODEM_OUT: next_prdata = {24'h000000, modem_out};
			OFF_ENH_FEAT:  next_prdata = {24'h000000, enh_feat};
			OFF_FEAT_CTL:  next_prdata = {24'h000000, feat_ctl};
			OFF_STATUS:    next_prdata = status_word;
			default:       next_prdata = 32'h00000000;
		endcase
	end

	// Read data captured in the setup cycle, stable through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (setup) begin
			prdata <= next_prdata;
		end
	end

	fc_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL2]
		(wr_fc && !pwdata[FC_ENABLE]) |=> $stable(fifo_cfg.rx_trig)
		&& $stable(fifo_cfg.tx_trig) && !fifo_cfg.enable)
		else $error("fifo fields loaded without enable");

	rx_reset_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL3]
		rx_clr |=> rx_level == '0 && rx_fifo_clr ##1 !rx_fifo_clr || rx_clr)
		else $error("receive fifo reset failed");

	tx_reset_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL4]
		tx_clr |=> tx_level == '0 && tx_fifo_clr)
		else $error("transmit fifo reset failed");

	tx_trig_lock_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL6]
		(fc_ok && !enh_feat[EF_ENHANCED]) |=> $stable(fifo_cfg.tx_trig))
		else $error("tx trigger written without enhanced enable");

	no_fifo_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL1]
		!fifo_cfg.enable |-> tx_level <= LVL_W'(1) && rx_level <= LVL_W'(1))
		else $error("non-fifo mode holds more than one character");

	tx_req_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL7]
		(fifo_cfg.enable && tx_free > tx_trig_lvl) |=> tx_irq_req)
		else $error("transmit request missing");

	rx_req_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL9]
		(fifo_cfg.enable && (rx_level > rx_trig_lvl || rx_timeout))
		|=> rx_irq_req) else $error("receive request missing");

	break_low_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL15]
		line_fmt[LF_BREAK] |=> !tx_pin) else $error("break not held low");

	modem_out_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL17]
		##1 term_ready_n == !$past(modem_out[MO_TERM_RDY]))
		else $error("terminal ready level wrong");

	send_req_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL18]
		(!feat_ctl[FT_RS485] && !enh_feat[EF_AUTO_SEND])
		|=> send_req_n == !$past(modem_out[MO_SEND_REQ]))
		else $error("send request level wrong");

	force_par_a: assert property (@(posedge pclk) disable iff (!presetn) // [RL14]
		fmt.parity_forced |=> tx_parity_bit == !$past(fmt.parity_even))
		else $error("forced parity wrong");

endmodule : ufc_uart_ctl

// >>> verif/ufc_far_end.sv
`timescale 1ns/1ps
module ufc_far_end (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic push_go,
	output logic      bit_tick,
	output logic      rx_push,
	output logic      rx_activity,
	output logic      rx_check,
	output logic      rx_parity_in,
	output logic [7:0] rx_char
);
	logic [1:0] div;

	// Remote sender: one character per cycle of push_go, new value each
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div          <= 2'h0;
			bit_tick     <= 1'b0;
			rx_push      <= 1'b0;
			rx_activity  <= 1'b0;
			rx_check     <= 1'b0;
			rx_parity_in <= 1'b0;
			rx_char      <= 8'h00;
		end else begin
			div          <= div + 2'h1;
			bit_tick     <= div == 2'h3;
			rx_push      <= push_go;
			rx_activity  <= push_go;
			rx_check     <= push_go;
			rx_parity_in <= ~rx_parity_in;
			rx_char      <= rx_char + 8'h11;
		end
	end
endmodule : ufc_far_end

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench
	import ufc_pkg::*;
;
	logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]    paddr, tx_char, rx_char, host_wr_byte, div_low, div_high;
	logic [31:0]   pwdata, prdata, rd, seed;
	logic          err, push_go, bit_tick, rx_push, rx_activity;
	logic          tx_busy, auto_send_req_n;
	logic          rx_check, rx_parity_in, tx_pin, term_ready_n;
	logic          send_req_n, host_wr_valid, tx_fifo_clr, rx_fifo_clr;
	logic          tx_parity_bit, rx_parity_err, tx_irq_req, rx_irq_req;
	logic [3:0]    div_frac;
	ufc_fmt_t      fmt;
	ufc_fifo_cfg_t fifo_cfg;
	int            miscompares, compares, line_format_control, i, tout;

	ufc_uart_ctl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .bit_tick,
		.tx_serial_bit(1'b1), .tx_pop(1'b0), .tx_busy, .tx_char,
		.rx_push, .rx_activity, .rx_char, .rx_parity_in, .rx_check,
		.auto_send_req_n, .tx_pin, .term_ready_n, .send_req_n,
		.host_wr_valid, .host_wr_byte, .tx_fifo_clr, .rx_fifo_clr,
		.tx_parity_bit, .rx_parity_err, .tx_irq_req, .rx_irq_req, .fmt,
		.fifo_cfg, .div_low, .div_high, .div_frac);

	ufc_far_end far (.pclk, .presetn, .push_go, .bit_tick, .rx_push,
		.rx_activity, .rx_check, .rx_parity_in, .rx_char);

	always #50 pclk = ~pclk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic give_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] s);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : tick

	// Holds the whole request until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			miscompares++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Parity is off during pushes, so no strobe may flag an error
	task automatic push(input int n);
		repeat (n) begin
			@(posedge pclk);
			push_go <= 1'b1;
			#1;
			chk("perr off", 0, rx_parity_err);
		end
		@(posedge pclk);
		push_go <= 1'b0;
	endtask : push

	initial begin
		pclk = 0;
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		tx_char = 0;
		push_go = 0;
		tx_busy = 0;
		auto_send_req_n = 1;
		seed = 32'h1F4E;
		miscompares = 0;
		compares = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		tick(2);
		apb(0, OFF_LINE_FMT, 0);
		chk("fmt rst", 32'h05, rd);
		chk("wbits rst", 6, fmt.word_bits);
		chk("stop rst", 1, fmt.stop_two);
		chk("dtr rst", 1, term_ready_n);
		chk("rts rst", 1, send_req_n);
		chk("tx rst", 1, tx_pin);
		apb(0, OFF_FIFO_CTL, 0);
		chk("fifo rd rst", 0, rd);
		chk("fifo en rst", 0, fifo_cfg.enable);
		// Every word code and parity mode, random stop and break
		for (i = 0; i < 32; i++) begin
			seed = lfsr(seed);
			line_format_control = {seed[6], i[4:2], seed[2], i[1:0]};
			@(posedge pclk);
			tx_char <= seed[15:8];
			apb(1, OFF_LINE_FMT, line_format_control);
			tick(3);
			chk("wbits", 5 + line_format_control[1:0], fmt.word_bits);
			chk("stop2", line_format_control[2] && line_format_control[1:0] != 0, fmt.stop_two);
			chk("stop15", line_format_control[2] && line_format_control[1:0] == 0, fmt.stop_half);
			chk("par", {line_format_control[3], line_format_control[5], line_format_control[4]}, {fmt.parity_en,
				fmt.parity_forced, fmt.parity_even});
			if (line_format_control[3])
				chk("txpar", line_format_control[5] ? !line_format_control[4] : !line_format_control[4]
					^ ^(seed[15:8] & (8'hFF >> (3 - line_format_control[1:0]))),
					tx_parity_bit);
			chk("brk", !line_format_control[6], tx_pin);
			apb(0, OFF_LINE_FMT, 0);
			chk("fmt rd", line_format_control, rd);
		end
		apb(1, OFF_LINE_FMT, 8'h03);
		for (i = 0; i < 4; i++) begin
			apb(1, OFF_MODEM_OUT, i);
			tick(3);
			chk("dtr", !i[0], term_ready_n);
			chk("rts", !i[1], send_req_n);
		end
		apb(1, OFF_ENH_FEAT, 8'h40);
		tick(3);
		chk("rts auto", 1, send_req_n);
		apb(1, OFF_FEAT_CTL, 8'h08);
		tx_busy <= 1'b1;
		tick(3);
		chk("rts dir", 0, send_req_n);
		@(posedge pclk);
		tx_busy <= 1'b0;
		tick(3);
		chk("rts idle", 1, send_req_n);
		apb(1, OFF_FEAT_CTL, 0);
		apb(1, OFF_ENH_FEAT, 0);
		apb(1, OFF_DIV_HIGH, 8'h5A);
		chk("div hidden", 1, err);
		apb(1, OFF_DATA, 8'hC3);
		tick(0);
		chk("data wr", 9'h1C3, {host_wr_valid, host_wr_byte});
		apb(1, OFF_LINE_FMT, 8'h83);
		apb(1, OFF_DATA, 8'h21);
		apb(1, OFF_DIV_HIGH, 8'h34);
		tick(1);
		chk("div", 17'h3421, {host_wr_valid, div_high, div_low});
		apb(1, OFF_DIV_FRAC, 8'hA7);
		apb(0, OFF_DIV_FRAC, 0);
		chk("div frac", 4'h7, rd);
		apb(1, OFF_LINE_FMT, 8'h03);
		apb(0, 8'h3C, 0);
		chk("unmapped", 1, err);
		// Trigger fields load only with enable in the same write
		apb(1, OFF_FIFO_CTL, 8'hF0);
		tick(1);
		chk("cfg noen", 0, fifo_cfg);
		apb(1, OFF_FIFO_CTL, 8'hF9);
		tick(1);
		chk("cfg noenh", 5'h13, fifo_cfg);
		apb(0, OFF_FIFO_CTL, 0);
		chk("fifo rd", 8'hC0, rd);
		apb(1, OFF_ENH_FEAT, 8'h10);
		for (i = 0; i < 4; i++) begin
			apb(1, OFF_FIFO_CTL, {i[1:0], i[1:0], 4'h1});
			tick(1);
			chk("cfg", {1'b1, i[1:0], i[1:0]}, fifo_cfg);
		end
		apb(1, OFF_FIFO_CTL, 8'h06);
		tick(0);
		chk("clr off", 2'h3, {tx_fifo_clr, rx_fifo_clr});
		chk("fifo off", 0, fifo_cfg.enable);
		apb(1, OFF_FIFO_CTL, 8'h06);
		tick(0);
		chk("clr noen", 0, {tx_fifo_clr, rx_fifo_clr});
		apb(1, OFF_FIFO_CTL, 8'h01);
		push(8);
		tick(4);
		chk("rxreq 8", 0, rx_irq_req);
		push(1);
		tick(4);
		chk("rxreq 9", 1, rx_irq_req);
		apb(0, OFF_STATUS, 0);
		chk("rx lvl", 9, rd[14:8]);
		apb(1, OFF_FIFO_CTL, 8'h03);
		tick(0);
		chk("rx clr", 2'h1, {tx_fifo_clr, rx_fifo_clr});
		tick(1);
		chk("rx clr end", 0, rx_fifo_clr);
		tick(2);
		chk("rxreq clr", 0, rx_irq_req);
		// Word 8, no parity, one stop
		tout = 4 * (1 + 8 + 1) + 12;
		push(1);
		tick(4 * tout - 16);
		chk("tout early", 0, rx_irq_req);
		tick(40);
		chk("tout", 1, rx_irq_req);
		apb(0, OFF_STATUS, 0);
		chk("tout stat", 1, rd[19]);
		chk("fifo stat", 1, rd[18]);
		apb(0, OFF_DATA, 0);
		tick(3);
		chk("tout read", 0, rx_irq_req);
		chk("txreq empty", 1, tx_irq_req);
		for (i = 1; i <= 56; i++) begin
			apb(1, OFF_DATA, i);
			tick(4);
			chk("txreq", (64 - i) > 8, tx_irq_req);
		end
		apb(0, OFF_STATUS, 0);
		chk("tx lvl", 56, rd[6:0]);
		apb(1, OFF_FIFO_CTL, 8'h05);
		tick(0);
		chk("tx clr", 2'h2, {tx_fifo_clr, rx_fifo_clr});
		tick(3);
		chk("txreq clr", 1, tx_irq_req);
		give_verdict();
	end
endmodule : testbench
